// ===== asc_map.vh
// constants, field positions and delays for the adc setup/scan decoder
`ifndef ASC_MAP_VH
`define ASC_MAP_VH
`define ASC_SETUP_RESET 6'h28
`define ASC_CLK_HI 5
`define ASC_CLK_LO 4
`define ASC_REF_HI 3
`define ASC_REF_LO 2
`define ASC_DIFF_HI 1
`define ASC_DIFF_LO 0
`define ASC_CH_HI 5
`define ASC_CH_LO 3
`define ASC_SCAN_HI 2
`define ASC_SCAN_LO 1
`define ASC_TEMP_BIT 0
`define ASC_DLY_FORCED 9'd188
`define ASC_DLY_WAKE 9'd218
`define ASC_DLY_TEMP 9'd244
`define ASC_CONV_CYC 5'd16
`define ASC_TOP_CH 3'h7
`endif

// ===== asc_ctrl.v
// setup and scan command decoder with reference power and scan sequencing
`timescale 1ns/100ps
`include "asc_map.vh"
module asc_ctrl (
    input wire clk_sys,
    input wire rst_b,
    input wire sclk,
    input wire cs_b,
    input wire din,
    input wire conversion_start_pin,
    input wire int_osc_tick,
    input wire force_bandgap_on,
    input wire dac_ref_load,
    input wire [1:0] avg_count_sel,
    input wire four_input_part,
    output reg [1:0] clock_mode_q,
    output reg [1:0] reference_mode_q,
    output reg [7:0] unipolar_q,
    output reg [7:0] bipolar_q,
    output reg ref_power_q,
    output reg start_is_analog_input_seven_q,
    output reg reference_two_pin_is_input_q,
    output reg scan_busy_q,
    output reg conv_strobe_q,
    output reg conv_is_temp_q,
    output reg [2:0] conv_channel_q
);
    localparam ST_IDLE = 4'b0001;
    localparam ST_WAIT = 4'b0010;
    localparam ST_CONV = 4'b0100;
    localparam ST_NEXT = 4'b1000;

    // two-flop synchronisers for pins from outside this clock
    reg [1:0] sclk_s_q;
    reg [1:0] cs_s_q;
    reg [1:0] din_s_q;
    reg [1:0] cnv_s_q;
    reg sclk_d1_q;
    reg cnv_d1_q;
    reg [7:0] shift_q;
    reg [2:0] bit_cnt_q;
    reg data_pending_q;
    reg data_to_bip_q;
    reg [2:0] channel_q;
    reg [1:0] scan_mode_q;
    reg temp_req_q;
    reg [3:0] state_q;
    reg [8:0] delay_q;
    reg [4:0] conv_cnt_q;
    reg [3:0] repeat_q;
    reg temp_pending_q;
    reg ref_hold_q;

    // reset image of the setup byte: clock 10, reference 10, selector 00
    localparam [5:0] SETUP_RST = `ASC_SETUP_RESET;

    function [2:0] cmd_channel;
        input [7:0] cmd;
        begin
            cmd_channel = cmd[`ASC_CH_HI:`ASC_CH_LO];
        end
    endfunction

    function [1:0] cmd_scan_mode;
        input [7:0] cmd;
        begin
            cmd_scan_mode = cmd[`ASC_SCAN_HI:`ASC_SCAN_LO];
        end
    endfunction

    // highest channel that exists on this part
    function [2:0] top_channel;
        input four;
        begin
            top_channel = four ? 3'h3 : `ASC_TOP_CH;
        end
    endfunction

    // clock mode 11 counts serial clock edges, the others the oscillator
    function conv_tick;
        input [1:0] mode;
        input ser;
        input osc;
        begin
            if (mode == 2'b11)
                conv_tick = ser;
            else
                conv_tick = osc;
        end
    endfunction

    // settling wait before the first conversion of a scan
    function [8:0] start_wait;
        input temp;
        input forced;
        input need;
        input held;
        begin
            if (temp && forced)
                start_wait = `ASC_DLY_FORCED;
            else if (temp)
                start_wait = `ASC_DLY_TEMP;
            else if (need && !forced && !held)
                start_wait = `ASC_DLY_WAKE;
            else
                start_wait = 9'd0;
        end
    endfunction

    // true when the conversion just finished closes the scan
    function last_of_scan;
        input [1:0] mode;
        input [2:0] cur;
        input [2:0] sel;
        input [2:0] top;
        input [3:0] left;
        begin
            case (mode)
                2'b00: last_of_scan = (cur == sel);
                2'b01: last_of_scan = (cur >= top);
                2'b10: last_of_scan = (left == 4'h0);
                default: last_of_scan = 1'b1;
            endcase
        end
    endfunction

    wire sclk_rise = sclk_s_q[1] & ~sclk_d1_q;
    wire cnv_fall = ~cnv_s_q[1] & cnv_d1_q;
    wire cs_act = ~cs_s_q[1];
    wire [7:0] byte_in = {shift_q[6:0], din_s_q[1]};
    wire byte_done = cs_act & sclk_rise & (bit_cnt_q == 3'h7);
    wire is_scan = byte_done & ~data_pending_q & byte_in[7];
    wire is_setup = byte_done & ~data_pending_q & ~byte_in[7]
        & byte_in[6];
    wire tick = conv_tick(clock_mode_q, sclk_rise, int_osc_tick);
    // forced-on condition of the reference
    wire ref_forced = force_bandgap_on |
        ((reference_mode_q == 2'b00) & dac_ref_load);
    wire auto_start = (clock_mode_q[1] == 1'b1);
    wire [2:0] top_ch = top_channel(four_input_part);

    function [3:0] avg_results;
        input [1:0] sel;
        begin
            case (sel)
                2'b00: avg_results = 4'h3;
                2'b01: avg_results = 4'h7;
                2'b10: avg_results = 4'hb;
                default: avg_results = 4'hf;
            endcase
        end
    endfunction

    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            sclk_s_q <= 2'h0;
            cs_s_q <= 2'h3;
            din_s_q <= 2'h0;
            cnv_s_q <= 2'h3;
            sclk_d1_q <= 1'b0;
            cnv_d1_q <= 1'b1;
        end else begin
            sclk_s_q <= {sclk_s_q[0], sclk};
            cs_s_q <= {cs_s_q[0], cs_b};
            din_s_q <= {din_s_q[0], din};
            cnv_s_q <= {cnv_s_q[0], conversion_start_pin};
            sclk_d1_q <= sclk_s_q[1];
            cnv_d1_q <= cnv_s_q[1];
        end
    end

    // serial byte assembly and command decode
    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            shift_q <= 8'h00;
            bit_cnt_q <= 3'h0;
            data_pending_q <= 1'b0;
            data_to_bip_q <= 1'b0;
            clock_mode_q <= SETUP_RST[`ASC_CLK_HI:`ASC_CLK_LO];
            reference_mode_q <=
                SETUP_RST[`ASC_REF_HI:`ASC_REF_LO];
            unipolar_q <= 8'h00;
            bipolar_q <= 8'h00;
            channel_q <= 3'h0;
            scan_mode_q <= 2'b11;
            temp_req_q <= 1'b0;
        end else if (!cs_act) begin
            bit_cnt_q <= 3'h0;
            data_pending_q <= 1'b0;
        end else if (sclk_rise) begin
            shift_q <= byte_in;
            bit_cnt_q <= bit_cnt_q + 3'h1;
            if (byte_done) begin
                if (data_pending_q) begin
                    data_pending_q <= 1'b0;
                    if (data_to_bip_q)
                        bipolar_q <= byte_in;
                    else
                        unipolar_q <= byte_in;
                end else if (is_scan) begin
                    // bit 6 is not looked at
                    channel_q <= cmd_channel(byte_in);
                    scan_mode_q <= cmd_scan_mode(byte_in);
                    temp_req_q <= byte_in[`ASC_TEMP_BIT];
                end else if (is_setup) begin
                    clock_mode_q <= byte_in[`ASC_CLK_HI:`ASC_CLK_LO];
                    reference_mode_q <=
                        byte_in[`ASC_REF_HI:`ASC_REF_LO];
                    // only 1x selectors expect a data byte
                    data_pending_q <= byte_in[`ASC_DIFF_HI];
                    data_to_bip_q <= byte_in[`ASC_DIFF_LO];
                end
            end
        end
    end

    wire scan_go = (state_q == ST_IDLE) &
        ((auto_start & is_scan) | (~auto_start & cnv_fall));
    wire scan_temp = auto_start ? byte_in[`ASC_TEMP_BIT] : temp_req_q;
    // ordinary channels need the internal reference only in modes 00/10
    wire ref_needed = scan_temp |
        ~reference_mode_q[0];
    wire [8:0] start_delay =
        start_wait(scan_temp, ref_forced, ref_needed, ref_hold_q);
    wire [1:0] go_mode = auto_start ? cmd_scan_mode(byte_in) : scan_mode_q;
    wire [2:0] go_ch = auto_start ? cmd_channel(byte_in) : channel_q;
    wire last_conv = ~temp_pending_q & last_of_scan(scan_mode_q,
        conv_channel_q, channel_q, top_ch, repeat_q);

    // scan sequencer; a scan latched on its own start uses fresh fields
    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            state_q <= ST_IDLE;
            delay_q <= 9'd0;
            conv_cnt_q <= 5'd0;
            repeat_q <= 4'h0;
            temp_pending_q <= 1'b0;
            ref_hold_q <= 1'b0;
            scan_busy_q <= 1'b0;
            conv_strobe_q <= 1'b0;
            conv_is_temp_q <= 1'b0;
            conv_channel_q <= 3'h0;
        end else begin
            conv_strobe_q <= 1'b0;
            case (state_q)
                ST_IDLE: begin
                    if (scan_go) begin
                        state_q <= ST_WAIT;
                        scan_busy_q <= 1'b1;
                        delay_q <= start_delay;
                        ref_hold_q <= ref_needed;
                        temp_pending_q <= scan_temp;
                        repeat_q <= avg_results(avg_count_sel);
                        conv_channel_q <= (go_mode == 2'b00) ? 3'h0
                                                             : go_ch;
                    end else if (!ref_forced) begin
                        ref_hold_q <= 1'b0;
                    end
                end
                ST_WAIT: begin
                    if (delay_q == 9'd0) begin
                        state_q <= ST_CONV;
                        conv_cnt_q <= `ASC_CONV_CYC;
                        conv_strobe_q <= 1'b1;
                        conv_is_temp_q <= temp_pending_q;
                    end else if (tick) begin
                        delay_q <= delay_q - 9'd1;
                    end
                end
                ST_CONV: begin
                    if (conv_cnt_q == 5'd0)
                        state_q <= ST_NEXT;
                    else if (tick)
                        conv_cnt_q <= conv_cnt_q - 5'd1;
                end
                ST_NEXT: begin
                    if (last_conv) begin
                        state_q <= ST_IDLE;
                        scan_busy_q <= 1'b0;
                        conv_is_temp_q <= 1'b0;
                    end else begin
                        state_q <= ST_CONV;
                        conv_cnt_q <= `ASC_CONV_CYC;
                        conv_strobe_q <= 1'b1;
                        conv_is_temp_q <= 1'b0;
                        if (temp_pending_q)
                            temp_pending_q <= 1'b0;
                        else if (scan_mode_q == 2'b10)
                            repeat_q <= repeat_q - 4'h1;
                        else
                            conv_channel_q <= conv_channel_q + 3'h1;
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    // reference power and pin role outputs
    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            ref_power_q <= 1'b0;
            start_is_analog_input_seven_q <= 1'b1;
            reference_two_pin_is_input_q <= 1'b1;
        end else begin
            ref_power_q <= ref_forced | (scan_busy_q & ref_hold_q);
            start_is_analog_input_seven_q <= clock_mode_q[1];
            reference_two_pin_is_input_q <= ~reference_mode_q[0];
        end
    end
endmodule

// ===== asc_ctrl_asserts.sv
// port-level assertions for the setup and scan command decoder
`timescale 1ns/100ps
module asc_chk (
    input logic clk_sys,
    input logic rst_b,
    input logic force_bandgap_on,
    input logic dac_ref_load,
    input logic four_input_part,
    input logic [1:0] clock_mode_q,
    input logic [1:0] reference_mode_q,
    input logic ref_power_q,
    input logic start_is_analog_input_seven_q,
    input logic reference_two_pin_is_input_q,
    input logic scan_busy_q,
    input logic conv_strobe_q,
    input logic conv_is_temp_q,
    input logic [2:0] conv_channel_q
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    // a scan that starts with nothing holding the reference up
    sequence s_cold;
        $rose(scan_busy_q) && !force_bandgap_on && !dac_ref_load
            && !reference_mode_q[0];
    endsequence
    sequence s_quiet;
        !conv_strobe_q [*8];
    endsequence
    property p_analog_input_seven;
        $stable(clock_mode_q) |-> start_is_analog_input_seven_q == clock_mode_q[1];
    endproperty
    a_analog_input_seven: assert property (p_analog_input_seven)
        else $error("start pin role wrong");
    property p_reference_two_pin;
        $stable(reference_mode_q) |-> reference_two_pin_is_input_q == !reference_mode_q[0];
    endproperty
    a_reference_two_pin: assert property (p_reference_two_pin)
        else $error("reference two pin role wrong");
    property p_force;
        force_bandgap_on [*3] |-> ref_power_q;
    endproperty
    a_force: assert property (p_force)
        else $error("forced reference not on");
    property p_ref00;
        (reference_mode_q == 2'h0 && dac_ref_load) [*3] |-> ref_power_q;
    endproperty
    a_ref00: assert property (p_ref00)
        else $error("reference not held for outputs");
    property p_pulse;
        conv_strobe_q |=> !conv_strobe_q;
    endproperty
    a_pulse: assert property (p_pulse)
        else $error("conversion strobe too long");
    property p_in_scan;
        conv_strobe_q |-> scan_busy_q;
    endproperty
    a_in_scan: assert property (p_in_scan)
        else $error("conversion outside a scan");
    property p_temp_ref;
        conv_is_temp_q |-> ref_power_q;
    endproperty
    a_temp_ref: assert property (p_temp_ref)
        else $error("temperature without reference");
    property p_four;
        conv_strobe_q && four_input_part && !conv_is_temp_q
            |-> !conv_channel_q[2];
    endproperty
    a_four: assert property (p_four)
        else $error("channel beyond four-input range");
    property p_cold;
        s_cold |=> s_quiet;
    endproperty
    a_cold: assert property (p_cold)
        else $error("conversion before reference wake");
endmodule

bind asc_ctrl asc_chk chk (.*);

// ===== asc_host.sv
// host serial master that shifts command bytes into the decoder
`timescale 1ns/100ps
module asc_host (
    output logic sclk,
    output logic cs_b,
    output logic din
);
    initial begin
        sclk = 1'b0;
        cs_b = 1'b1;
        din = 1'b0;
    end
    // keep holds select low so a data byte can follow its setup byte
    task send(input logic [7:0] b, input logic keep);
        cs_b = 1'b0;
        for (int i = 7; i >= 0; i--) begin
            din = b[i];
            #80 sclk = 1'b1;
            #80 sclk = 1'b0;
        end
        if (!keep) begin
            #80 cs_b = 1'b1;
            // a released line shows the inverse, so a stale bit never passes
            din = !b[0];
            #160;
        end
    endtask
endmodule

// ===== tb_top.sv
// self-checking bench for the setup and scan command decoder
`timescale 1ns/100ps
module tb_top;
    logic clk_sys, rst_b, sclk, cs_b, din, conversion_start_pin;
    logic int_osc_tick, force_bandgap_on, dac_ref_load, four_input_part;
    logic [1:0] avg_count_sel, clock_mode_q, reference_mode_q;
    logic [7:0] unipolar_q, bipolar_q;
    logic ref_power_q, start_is_analog_input_seven_q, reference_two_pin_is_input_q, scan_busy_q;
    logic conv_strobe_q, conv_is_temp_q;
    logic [2:0] conv_channel_q;
    int failures = 0;
    int n_compared = 0;
    int cycles = 0;
    // oscillator ticks since the scan went busy, read at its first strobe
    int wait_n = 0;
    // command, data byte, expected unipolar, expected bipolar
    logic [31:0] rows [4] = '{32'h7e5a5a00, 32'h57a55aa5, 32'h41005aa5,
        32'h68005aa5};
    asc_host host (.sclk(sclk), .cs_b(cs_b), .din(din));
    asc_ctrl uut (.*);
    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end
    always @(negedge clk_sys) int_osc_tick <= ~int_osc_tick;
    always @(posedge clk_sys)
        wait_n <= scan_busy_q ? wait_n + int_osc_tick : 0;
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            failures++;
            report_and_stop();
        end
    end
    task chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    task report_and_stop;
        $display("compared %0d failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // temperature is listed as 8, a channel as its number
    task do_scan(input logic [7:0] cmd, input logic pin, input int dly);
        logic [3:0] q [$];
        logic [3:0] seen;
        int n, t;
        t = 0;
        if (cmd[0]) q.push_back(4'h8);
        for (int c = 0; c < 8; c++)
            if (cmd[2:1] == 0 ? c <= cmd[5:3] : cmd[2:1] == 1 &&
                c >= cmd[5:3] && c <= (four_input_part ? 3 : 7))
                q.push_back(4'(c));
        repeat (cmd[2:1] == 2 ? 4 * avg_count_sel + 4 : cmd[2:1] == 3)
            q.push_back({1'b0, cmd[5:3]});
        host.send(cmd, 1'b0);
        if (pin) begin
            chk("early_busy", scan_busy_q, 0);
            conversion_start_pin = 1'b0;
            repeat (4) @(negedge clk_sys);
            conversion_start_pin = 1'b1;
        end
        for (n = 0; n < 50 && !scan_busy_q; n++) @(negedge clk_sys);
        while (scan_busy_q && n < 4000) begin
            @(negedge clk_sys);
            n++;
            if (conv_strobe_q && t >= 0) begin
                t = wait_n;
                chk("delay", t >= dly && t <= dly + 2, 1);
                t = -1;
            end
            if (conv_strobe_q) begin
                seen = conv_is_temp_q ? 4'h8 : {1'b0, conv_channel_q};
                chk("chan", seen, q.size() ? q.pop_front() : 4'hf);
            end
        end
        chk("done", scan_busy_q, 0);
        chk("left", 8'(q.size()), 0);
    endtask
    initial begin
        {rst_b, conversion_start_pin, int_osc_tick, force_bandgap_on} = 4'h4;
        {dac_ref_load, four_input_part, avg_count_sel} = 4'h0;
        repeat (10) @(negedge clk_sys);
        rst_b = 1'b1;
        chk("clk_mode", clock_mode_q, 2'h2);
        chk("ref_mode", reference_mode_q, 2'h2);
        chk("ref_pwr", ref_power_q, 0);
        chk("analog_input_seven_rst", start_is_analog_input_seven_q, 1);
        chk("reference_two_pin_rst", reference_two_pin_is_input_q, 1);
        repeat (4) @(negedge clk_sys);
        foreach (rows[i]) begin
            host.send(rows[i][31:24], rows[i][25]);
            if (rows[i][25]) host.send(rows[i][23:16], 1'b0);
            repeat (8) @(negedge clk_sys);
            chk("clk_mode", clock_mode_q, rows[i][29:28]);
            chk("ref_mode", reference_mode_q, rows[i][27:26]);
            chk("analog_input_seven", start_is_analog_input_seven_q, rows[i][29]);
            chk("reference_two_pin", reference_two_pin_is_input_q, !rows[i][26]);
            chk("uni", unipolar_q, rows[i][15:8]);
            chk("bip", bipolar_q, rows[i][7:0]);
        end
        do_scan(8'hdf, 1'b0, 244);
        do_scan(8'ha8, 1'b0, 218);
        avg_count_sel = 2'h1;
        do_scan(8'h94, 1'b0, 218);
        four_input_part = 1'b1;
        do_scan(8'h8a, 1'b0, 218);
        four_input_part = 1'b0;
        force_bandgap_on = 1'b1;
        repeat (4) @(negedge clk_sys);
        chk("forced", ref_power_q, 1);
        do_scan(8'h87, 1'b0, 188);
        force_bandgap_on = 1'b0;
        host.send(8'h48, 1'b0);
        do_scan(8'hb6, 1'b1, 218);
        host.send(8'h40, 1'b0);
        dac_ref_load = 1'b1;
        repeat (6) @(negedge clk_sys);
        chk("held", ref_power_q, 1);
        dac_ref_load = 1'b0;
        host.send(8'h3f, 1'b0);
        repeat (8) @(negedge clk_sys);
        chk("ignored", clock_mode_q, 2'h0);
        report_and_stop();
    end
endmodule
